/* verilog/fpe_top.sv */
// Command decoder and self-timed sequencer for program and erase.
`timescale 1ns/10ps
`include "fpe_regs.svh"
module fpe_top #(
  parameter int unsigned PROG_CYCLES = `FPE_T_PROG_US * `FPE_CLK_MHZ,
  parameter int unsigned SE_CYCLES = `FPE_T_SE_US * `FPE_CLK_MHZ,
  parameter int unsigned BE32_CYCLES = `FPE_T_BE32_US * `FPE_CLK_MHZ,
  parameter int unsigned BE64_CYCLES = `FPE_T_BE64_US * `FPE_CLK_MHZ
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic data_line_0_in,
  input wire logic data_line_1_in,
  output logic data_line_1_out,
  output logic data_line_1_oe,
  input wire logic data_line_2_in,
  input wire logic data_line_3_in,
  input wire logic quad_io_enable_bit,
  input wire logic four_byte_mode,
  input wire logic qpi_mode,
  input wire logic protect_complement_bit,
  input wire logic protect_top_bottom_bit,
  input wire logic block_protect_bit3,
  input wire logic block_protect_bit2,
  input wire logic block_protect_bit1,
  input wire logic block_protect_bit0,
  input wire logic indiv_lock_hit,
  input wire logic wel_set,
  input wire logic wel_clear,
  output logic write_latch_flag,
  output logic busy_flag,
  output logic [31:0] target_addr,
  output logic mem_we,
  output logic mem_erase,
  output fpe_pkg::fpe_size_e mem_erase_size,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic cmd_reject
);
  import fpe_pkg::*;

  // ----------------------------------------------------------------
  // Opcode helpers
  // ----------------------------------------------------------------
  function automatic logic is_prog(input logic [7:0] op);
    return op == `FPE_OP_PP4B || op == `FPE_OP_QPP || op == `FPE_OP_QPP4B;
  endfunction
  function automatic logic is_erase(input logic [7:0] op);
    return op == `FPE_OP_SE || op == `FPE_OP_SE4B || op == `FPE_OP_BE32 ||
      op == `FPE_OP_BE64 || op == `FPE_OP_BE64_4B;
  endfunction
  function automatic logic is_quad(input logic [7:0] op);
    return op == `FPE_OP_QPP || op == `FPE_OP_QPP4B;
  endfunction
  function automatic logic is_4b_op(input logic [7:0] op);
    return op == `FPE_OP_PP4B || op == `FPE_OP_QPP4B ||
      op == `FPE_OP_SE4B || op == `FPE_OP_BE64_4B;
  endfunction
  function automatic fpe_size_e size_of(input logic [7:0] op);
    fpe_size_e s;
    s = sz_page;
    if (op == `FPE_OP_SE || op == `FPE_OP_SE4B) s = sz_4k;
    if (op == `FPE_OP_BE32) s = sz_32k;
    if (op == `FPE_OP_BE64 || op == `FPE_OP_BE64_4B) s = sz_64k;
    return s;
  endfunction
  function automatic logic [31:0] size_mask(input fpe_size_e s);
    logic [31:0] m;
    m = `FPE_MASK_PAGE;
    if (s == sz_4k) m = `FPE_MASK_4K;
    if (s == sz_32k) m = `FPE_MASK_32K;
    if (s == sz_64k) m = `FPE_MASK_64K;
    return m;
  endfunction
  // Protected 64 KB blocks count up from the bottom or down from the top.
  function automatic logic is_protected(input logic [31:0] a,
      input logic [3:0] bp, input logic tb, input logic cmp);
    logic [10:0] blk;
    logic [10:0] n;
    logic hit;
    blk = {1'b0, a[`FPE_BLK_MSB:`FPE_BLK_LSB]};
    n = '0;
    if (bp >= `FPE_BP_ALL) n = `FPE_BLK_TOTAL;
    else if (bp != 4'h0) n = 11'(11'h001 << (bp - 4'h1));
    hit = tb ? (blk < n) : (blk >= 11'(`FPE_BLK_TOTAL - n));
    return hit ^ cmp;
  endfunction

  // ----------------------------------------------------------------
  // Settings carried into the link domain
  // ----------------------------------------------------------------
  logic [3:0] cfg_reg;
  logic [3:0] link_cfg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cfg_reg <= '0;
    else cfg_reg <= {qpi_mode, four_byte_mode, write_latch_flag, busy_flag};
  end
  fpe_sync #(.W(4)) u_cfg_sync (
    .clk(sclk),
    .resetn(resetn),
    .d(cfg_reg),
    .q(link_cfg)
  );
  wire logic link_busy = link_cfg[0];
  wire logic link_wel = link_cfg[1];
  wire logic link_4b = link_cfg[2];
  wire logic link_qpi = link_cfg[3];

  // ----------------------------------------------------------------
  // Link shifter on the serial clock
  // ----------------------------------------------------------------
  logic fresh_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [9:0] byte_cnt_reg;
  logic [7:0] opcode_reg;
  logic [31:0] addr_reg;
  logic [2:0] addr_len_reg;
  logic [7:0] data_idx_reg;
  logic [2:0] sr_bit_reg;

  // Counting restarts on the first edge after select has been high, so
  // the captured frame stays put for the system side once select rises.
  wire logic [2:0] bit_cur = fresh_reg ? 3'h0 : bit_cnt_reg;
  wire logic [9:0] byte_cur = fresh_reg ? 10'h000 : byte_cnt_reg;
  wire logic in_data = byte_cur > {7'h00, addr_len_reg};
  wire logic quad_lane = link_qpi ||
    (in_data && is_quad(opcode_reg));
  wire logic [7:0] shift_next = quad_lane ?
    {shift_reg[3:0], data_line_3_in, data_line_2_in, data_line_1_in,
     data_line_0_in} : {shift_reg[6:0], data_line_0_in};
  wire logic byte_done = bit_cur ==
    (quad_lane ? `FPE_LAST_BIT_4 : `FPE_LAST_BIT_1);
  wire logic [2:0] bit_next = byte_done ? 3'h0 :
    bit_cur + (quad_lane ? `FPE_STEP_4 : `FPE_STEP_1);
  wire logic opcode_done = byte_done && byte_cur == 10'h000;
  wire logic addr_byte = byte_done && !in_data && byte_cur != 10'h000;
  // No fresh data is taken while a cycle is in flight, so the bytes the
  // sequencer is draining cannot change, though a new frame clears the written mask.
  wire logic data_wr = byte_done && in_data && is_prog(opcode_reg) &&
    !link_busy;
  wire logic [7:0] data_wr_idx = addr_reg[7:0] + data_idx_reg;
  wire logic [7:0] status_byte = {6'h00, link_wel, link_busy};
  wire logic [2:0] addr_len_new = (is_4b_op(shift_next) || link_4b) ?
    `FPE_ADDR_4B : `FPE_ADDR_3B;

  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      byte_cnt_reg <= '0;
      opcode_reg <= '0;
      addr_reg <= '0;
      addr_len_reg <= `FPE_ADDR_3B;
      data_idx_reg <= '0;
    end else begin
      bit_cnt_reg <= bit_next;
      shift_reg <= shift_next;
      if (byte_done && byte_cur != `FPE_BYTE_CAP) begin
        byte_cnt_reg <= byte_cur + 10'h001;
      end else begin
        byte_cnt_reg <= byte_cur;
      end
      if (fresh_reg) addr_reg <= '0;
      if (fresh_reg) data_idx_reg <= '0;
      if (opcode_done) begin
        opcode_reg <= shift_next;
        addr_len_reg <= addr_len_new;
      end
      if (addr_byte) addr_reg <= {addr_reg[23:0], shift_next};
      if (data_wr) data_idx_reg <= data_idx_reg + 8'h01;
    end
  end

  // Status answer; the output enable drops as soon as select rises.
  always_ff @(posedge sclk or posedge cs_n or negedge resetn) begin
    if (!resetn) begin
      fresh_reg <= 1'b1;
      data_line_1_oe <= 1'b0;
      data_line_1_out <= 1'b0;
      sr_bit_reg <= '0;
    end else if (cs_n) begin
      fresh_reg <= 1'b1;
      data_line_1_oe <= 1'b0;
      data_line_1_out <= 1'b0;
      sr_bit_reg <= '0;
    end else begin
      fresh_reg <= 1'b0;
      if (opcode_done && shift_next == `FPE_OP_RDSR) begin
        data_line_1_oe <= 1'b1;
        data_line_1_out <= status_byte[`FPE_SR_TOP];
        sr_bit_reg <= `FPE_SR_TOP - 3'h1;
      end else if (data_line_1_oe) begin
        data_line_1_out <= status_byte[sr_bit_reg];
        sr_bit_reg <= sr_bit_reg - 3'h1;
      end
    end
  end

  a_status_drive: assert property (
    @(posedge sclk) disable iff (cs_n || !resetn)
    (!fresh_reg && byte_cnt_reg == 10'h001 && opcode_reg == `FPE_OP_RDSR)
    |-> data_line_1_oe)
    else $error("status read not answered on data line 1");

  logic [7:0] rd_idx_reg;
  logic [7:0] buf_data;
  logic buf_written;
  fpe_page_buf u_page_buf (
    .wclk(sclk),
    .resetn(resetn),
    .wr_clear(fresh_reg),
    .wr_en(data_wr),
    .wr_idx(data_wr_idx),
    .wr_data(shift_next),
    .rd_idx(rd_idx_reg),
    .rd_data(buf_data),
    .rd_written(buf_written)
  );

  // ----------------------------------------------------------------
  // Frame end detection on the system clock
  // ----------------------------------------------------------------
  logic cs_sync;
  logic cs_last_reg;
  fpe_sync #(.W(1)) u_cs_sync (
    .clk(clk),
    .resetn(resetn),
    .d(cs_n),
    .q(cs_sync)
  );
  wire logic frame_end = cs_sync && !cs_last_reg;

  // Link registers are read here only while select is high and the
  // serial clock is parked, so they are stable when sampled.
  wire logic fr_prog = is_prog(opcode_reg);
  wire logic fr_erase = is_erase(opcode_reg);
  wire logic [9:0] fr_addr_end = {7'h00, addr_len_reg} + 10'h001;
  wire logic fr_whole = bit_cnt_reg == 3'h0;
  wire logic fr_len_ok = fr_erase ? byte_cnt_reg == fr_addr_end :
    byte_cnt_reg > fr_addr_end;
  wire logic fr_quad_ok = !is_quad(opcode_reg) || quad_io_enable_bit;
  wire logic fr_mode_ok = !qpi_mode ||
    !(is_4b_op(opcode_reg) || is_quad(opcode_reg));
  wire logic fr_cmd = (fr_prog || fr_erase) && byte_cnt_reg != 10'h000;
  wire logic fr_ok = fr_whole && fr_len_ok && fr_quad_ok && fr_mode_ok &&
    write_latch_flag;
  wire fpe_size_e fr_size = size_of(opcode_reg);
  wire logic [31:0] fr_target = addr_reg & ~size_mask(fr_size);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  fpe_state_e state_reg;
  fpe_size_e size_reg;
  logic [31:0] timer_reg;
  logic prog_op_reg;
  logic done_clr;

  wire logic [3:0] bp_bits = {block_protect_bit3, block_protect_bit2,
    block_protect_bit1, block_protect_bit0};
  wire logic target_locked = indiv_lock_hit ||
    is_protected(target_addr, bp_bits, protect_top_bottom_bit,
    protect_complement_bit);
  wire logic [31:0] run_cycles = (size_reg == sz_4k) ? SE_CYCLES :
    (size_reg == sz_32k) ? BE32_CYCLES :
    (size_reg == sz_64k) ? BE64_CYCLES : PROG_CYCLES;
  wire logic timer_zero = timer_reg == 32'h0000_0000;
  assign done_clr = state_reg == st_wait && timer_zero;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_last_reg <= 1'b1;
      state_reg <= st_idle;
      size_reg <= sz_page;
      prog_op_reg <= 1'b0;
      timer_reg <= '0;
      rd_idx_reg <= '0;
      target_addr <= '0;
      busy_flag <= 1'b0;
      mem_we <= 1'b0;
      mem_erase <= 1'b0;
      mem_erase_size <= sz_page;
      mem_addr <= '0;
      mem_wdata <= '0;
      cmd_reject <= 1'b0;
    end else begin
      cs_last_reg <= cs_sync;
      mem_we <= 1'b0;
      mem_erase <= 1'b0;
      cmd_reject <= 1'b0;
      if (!timer_zero) timer_reg <= timer_reg - 32'h0000_0001;
      unique case (state_reg)
        st_idle: begin
          if (frame_end && fr_cmd) begin
            if (fr_ok) begin
              state_reg <= st_check;
              size_reg <= fr_size;
              prog_op_reg <= fr_prog;
              target_addr <= fr_target;
            end else begin
              cmd_reject <= 1'b1;
            end
          end
        end
        st_check: begin
          if (target_locked) begin
            state_reg <= st_idle;
            cmd_reject <= 1'b1;
          end else begin
            busy_flag <= 1'b1;
            timer_reg <= run_cycles;
            rd_idx_reg <= '0;
            mem_addr <= target_addr;
            mem_erase <= !prog_op_reg;
            mem_erase_size <= size_reg;
            state_reg <= prog_op_reg ? st_prog : st_wait;
          end
        end
        st_prog: begin
          // Writes walk the page from its base so wrapped bytes land in it.
          mem_we <= buf_written;
          mem_addr <= {target_addr[31:8], rd_idx_reg};
          mem_wdata <= buf_data;
          rd_idx_reg <= rd_idx_reg + 8'h01;
          if (rd_idx_reg == `FPE_IDX_LAST) state_reg <= st_wait;
        end
        st_wait: begin
          if (timer_zero) begin
            busy_flag <= 1'b0;
            state_reg <= st_idle;
          end
        end
      endcase
    end
  end

  // Write latch: a set arriving with a clear wins.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) write_latch_flag <= 1'b0;
    else if (wel_set) write_latch_flag <= 1'b1;
    else if (wel_clear || done_clr) write_latch_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_busy_needs_wel: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(busy_flag) |-> $past(write_latch_flag, 2))
    else $error("cycle started without write latch set");

  a_wel_done_clear: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(busy_flag) |=> (!write_latch_flag || $past(wel_set)))
    else $error("write latch not cleared at end of cycle");

  a_erase_aligned: assert property (
    @(posedge clk) disable iff (!resetn)
    mem_erase |-> (mem_addr & size_mask(mem_erase_size)) == 32'h0000_0000)
    else $error("erase address not aligned to region");

  a_busy_holds: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(busy_flag) |-> busy_flag [*8])
    else $error("busy dropped early");

  a_erase_in_busy: assert property (
    @(posedge clk) disable iff (!resetn)
    mem_erase |-> busy_flag ##1 busy_flag)
    else $error("erase issued outside busy cycle");

  a_prog_in_page: assert property (
    @(posedge clk) disable iff (!resetn)
    mem_we ##1 mem_we |-> mem_addr[31:8] == $past(mem_addr[31:8]))
    else $error("program left its page");

  a_quad_gated: assert property (
    @(posedge clk) disable iff (!resetn)
    (state_reg == st_idle && frame_end && fr_cmd && is_quad(opcode_reg) &&
     !quad_io_enable_bit) |=> state_reg == st_idle)
    else $error("quad program run without quad enable");

  a_locked_skip: assert property (
    @(posedge clk) disable iff (!resetn)
    (state_reg == st_check && target_locked) |=>
    (!busy_flag && cmd_reject && state_reg == st_idle))
    else $error("protected target was not skipped");

  a_partial_reject: assert property (
    @(posedge clk) disable iff (!resetn)
    (state_reg == st_idle && frame_end && fr_cmd && !fr_whole) |=>
    (cmd_reject && state_reg == st_idle))
    else $error("partial byte frame was executed");

  a_qpi_4b_reject: assert property (
    @(posedge clk) disable iff (!resetn)
    (state_reg == st_idle && frame_end && fr_cmd && qpi_mode &&
     is_4b_op(opcode_reg)) |=> !busy_flag ##1 state_reg == st_idle)
    else $error("4-byte opcode run in four-line mode");
endmodule

/* verilog/fpe_regs.svh */
// Constants of the flash program and erase sequencer.
`ifndef FPE_REGS_SVH
`define FPE_REGS_SVH
`define FPE_OP_PP4B 8'h12
`define FPE_OP_QPP 8'h32
`define FPE_OP_QPP4B 8'h34
`define FPE_OP_SE 8'h20
`define FPE_OP_SE4B 8'h21
`define FPE_OP_BE32 8'h52
`define FPE_OP_BE64 8'hD8
`define FPE_OP_BE64_4B 8'hDC
`define FPE_OP_RDSR 8'h05
`define FPE_ADDR_3B 3'h3
`define FPE_ADDR_4B 3'h4
`define FPE_LAST_BIT_1 3'h7
`define FPE_LAST_BIT_4 3'h4
`define FPE_STEP_1 3'h1
`define FPE_STEP_4 3'h4
`define FPE_SR_TOP 3'h7
`define FPE_BYTE_CAP 10'h3FF
`define FPE_IDX_LAST 8'hFF
`define FPE_MASK_4K 32'h0000_0FFF
`define FPE_MASK_32K 32'h0000_7FFF
`define FPE_MASK_64K 32'h0000_FFFF
`define FPE_MASK_PAGE 32'h0000_00FF
`define FPE_BLK_MSB 25
`define FPE_BLK_LSB 16
`define FPE_BLK_TOTAL 11'h400
`define FPE_BP_ALL 4'hB
`define FPE_CLK_MHZ 20
`define FPE_T_PROG_US 800
`define FPE_T_SE_US 50000
`define FPE_T_BE32_US 120000
`define FPE_T_BE64_US 150000
`endif

/* verilog/fpe_pkg.sv */
// Types shared by the flash program and erase sequencer.
package fpe_pkg;
  typedef enum logic [1:0] {st_idle, st_check, st_prog, st_wait} fpe_state_e;
  typedef enum logic [1:0] {sz_page, sz_4k, sz_32k, sz_64k} fpe_size_e;
endpackage

/* verilog/fpe_sync.sv */
// Three-stage synchroniser with agreement of the last two stages.
`timescale 1ns/10ps
module fpe_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  // A bit only moves once the second and third stages agree on it.
  wire logic [W-1:0] agree = ~(s2_reg ^ s3_reg);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q <= (agree & s3_reg) | (~agree & q);
    end
  end
endmodule

/* verilog/fpe_page_buf.sv */
// Page buffer: written on the link clock, read quasi-statically.
`timescale 1ns/10ps
module fpe_page_buf (
  input wire logic wclk,
  input wire logic resetn,
  input wire logic wr_clear,
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_idx,
  output logic [7:0] rd_data,
  output logic rd_written
);
  logic [7:0] mem [0:255];
  logic [255:0] written_reg;
  // The data array has no reset; the written mask alone marks what counts.
  always_ff @(posedge wclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end
  always_ff @(posedge wclk or negedge resetn) begin
    if (!resetn) begin
      written_reg <= '0;
    end else if (wr_clear) begin
      written_reg <= '0;
    end else if (wr_en) begin
      written_reg[wr_idx] <= 1'b1;
    end
  end
  assign rd_data = mem[rd_idx];
  assign rd_written = written_reg[rd_idx];
endmodule

/* sim/fpe_host_model.sv */
// Host-side serial controller model that drives frames onto the link.
`timescale 1ns/10ps
module fpe_host_model (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] dq,
  input wire logic line1
);
  // The link clock stands still and low between frames.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq = 4'h5;
  end
  task automatic tick(input logic [3:0] v);
    dq = v;
    #6 sclk = 1'b1;
    #6 sclk = 1'b0;
  endtask
  // Unused lanes toggle so a stale level is never mistaken for data.
  task automatic put(input logic [7:0] b, input bit q);
    if (q) begin
      tick(b[7:4]);
      tick(b[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) tick({~dq[3:1], b[i]});
    end
  endtask
  task automatic frame(input logic [7:0] o, input logic [31:0] a,
      input int na, input int nd, input logic [7:0] d, input int xb,
      input bit q);
    cs_n = 1'b0;
    #10 put(o, q);
    for (int k = na - 1; k >= 0; k--)
      put(a[8*k +: 8], q);
    // Data of the quad program opcodes rides four lanes.
    for (int k = 0; k < nd; k++) put(d + 8'(k), q | o[5]);
    for (int k = 0; k < xb; k++) tick({~dq[3:1], 1'b1});
    #10 cs_n = 1'b1;
    dq = ~dq;
  endtask
  task automatic status(output logic [7:0] s);
    cs_n = 1'b0;
    #10 put(8'h05, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      #6 s[i] = line1;
      sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    #10 cs_n = 1'b1;
    dq = ~dq;
  endtask
endmodule

/* sim/fpe_top_tb_top.sv */
// Self-checking bench for the program and erase sequencer.
`timescale 1ns/10ps
module fpe_top_tb_top;
  import fpe_pkg::*;
  localparam int PC = 300;
  localparam int SC = 20;
  localparam int B3 = 24;
  localparam int B6 = 28;
  logic clk, resetn, sclk, cs_n, line1, quad_io_enable_bit, four_byte_mode;
  logic qpi_mode, indiv_lock_hit, wel_set, wel_clear, write_latch_flag;
  logic busy_flag, mem_we, mem_erase, cmd_reject, data_line_1_out;
  logic data_line_1_oe;
  logic [3:0] bp, dq;
  logic [31:0] target_addr, mem_addr, er_addr, w_addr;
  logic [7:0] mem_wdata, st;
  logic [7:0] wmem [256];
  fpe_size_e mem_erase_size, er_size;
  int errors, tests_run, cyc, rejs, ers, wrs, blen;
  assign line1 = data_line_1_oe ? data_line_1_out : dq[1];
  fpe_top #(.PROG_CYCLES(PC), .SE_CYCLES(SC), .BE32_CYCLES(B3),
    .BE64_CYCLES(B6)) DUT (
    .clk, .resetn, .sclk, .cs_n, .data_line_0_in(dq[0]),
    .data_line_1_in(line1), .data_line_1_out, .data_line_1_oe,
    .data_line_2_in(dq[2]), .data_line_3_in(dq[3]),
    .quad_io_enable_bit, .four_byte_mode, .qpi_mode,
    .protect_complement_bit(1'b0), .protect_top_bottom_bit(1'b0),
    .block_protect_bit3(bp[3]), .block_protect_bit2(bp[2]),
    .block_protect_bit1(bp[1]), .block_protect_bit0(bp[0]),
    .indiv_lock_hit, .wel_set, .wel_clear, .write_latch_flag,
    .busy_flag, .target_addr, .mem_we, .mem_erase, .mem_erase_size,
    .mem_addr, .mem_wdata, .cmd_reject);
  fpe_host_model host (.sclk, .cs_n, .dq, .line1);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------
  // Monitor and run control
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmd_reject) rejs <= rejs + 1;
    if (busy_flag) blen <= blen + 1;
    if (mem_erase) begin
      ers <= ers + 1;
      er_addr <= mem_addr;
      er_size <= mem_erase_size;
    end
    if (mem_we) begin
      wrs <= wrs + 1;
      w_addr <= mem_addr;
      wmem[mem_addr[7:0]] <= mem_wdata;
    end
    if (cyc == 6000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input string m);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Knobs k: latch, quad enable, 4-byte mode, qpi, lock hit, bp[3:0].
  // A status frame first lets the link-side copies of the modes settle.
  task automatic op(input logic [7:0] o, input logic [31:0] a, input int na,
      input int nd, input int xb, input logic [8:0] k, input bit poll);
    @(posedge clk);
    wel_set <= k[8];
    wel_clear <= !k[8];
    {quad_io_enable_bit, four_byte_mode, qpi_mode, indiv_lock_hit, bp} <=
      k[7:0];
    @(posedge clk);
    wel_set <= 1'b0;
    wel_clear <= 1'b0;
    host.status(st);
    repeat (10) @(posedge clk);
    chk(write_latch_flag, k[8], "latch");
    @(negedge clk);
    rejs = 0;
    ers = 0;
    wrs = 0;
    blen = 0;
    host.frame(o, a, na, nd, 8'hA0, xb, k[5]);
    if (poll) begin
      for (int i = 0; i < 40 && busy_flag !== 1'b1; i++) @(posedge clk);
      // Select must stay high for eight clocks between frames.
      repeat (8) @(posedge clk);
      host.status(st);
      chk(st, 8'h03, "status while busy");
    end
    for (int i = 0; i < 1000 && rejs == 0 && !(blen > 0 && !busy_flag); i++)
      @(posedge clk);
    repeat (12) @(posedge clk);
  endtask
  task automatic erase(input logic [7:0] o, input logic [31:0] a,
      input int na, input bit fb, input fpe_size_e sz, input logic [31:0] m,
      input int n, input bit poll);
    op(o, a, na, 0, 0, {2'b10, fb, 6'h00}, poll);
    chk(ers, 1, "erase pulses");
    chk(er_addr, a & ~m, "erase base");
    chk(target_addr, a & ~m, "target");
    chk({30'h0, er_size}, {30'h0, sz}, "erase size");
    chk(blen, n + 1, "busy length");
    chk(write_latch_flag, 1'b0, "latch after");
  endtask
  task automatic rj(input logic [7:0] o, input int nd, input int xb,
      input logic [8:0] k);
    op(o, 32'h0012_3456, 3 + o[0], nd, xb, k, 1'b0);
    chk(rejs, 1, "reject pulse");
    chk(blen + ers + wrs, 0, "nothing ran");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {resetn, quad_io_enable_bit, four_byte_mode, qpi_mode} = 4'h0;
    {indiv_lock_hit, wel_set, wel_clear, bp} = 7'h00;
    {errors, tests_run, cyc, rejs, ers, wrs, blen} = '0;
    repeat (4) @(posedge clk);
    chk({busy_flag, write_latch_flag, data_line_1_oe}, 3'h0, "reset");
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    erase(8'h20, 32'h0012_3456, 3, 0, sz_4k, 32'hFFF, SC, 1);
    erase(8'h21, 32'h0123_4567, 4, 0, sz_4k, 32'hFFF, SC, 0);
    erase(8'h52, 32'h0012_3456, 3, 0, sz_32k, 32'h7FFF, B3, 0);
    erase(8'hD8, 32'h0012_3456, 3, 0, sz_64k, 32'hFFFF, B6, 0);
    erase(8'hDC, 32'h0123_4567, 4, 0, sz_64k, 32'hFFFF, B6, 0);
    erase(8'h20, 32'h0123_4567, 4, 1, sz_4k, 32'hFFF, SC, 0);
    op(8'h32, 32'h0000_10FE, 3, 3, 0, 9'h180, 0);
    chk(wrs, 3, "bytes written");
    chk(wmem[8'hFE], 8'hA0, "byte 0");
    chk(wmem[8'hFF], 8'hA1, "byte 1");
    chk(wmem[8'h00], 8'hA2, "wrapped byte");
    chk(w_addr & 32'hFFFF_FF00, 32'h0000_1000, "page");
    chk(blen, PC + 1, "program busy");
    op(8'h34, 32'h0200_0005, 4, 1, 0, 9'h180, 0);
    chk(w_addr, 32'h0200_0005, "quad 4-byte");
    op(8'h12, 32'h0300_0080, 4, 1, 0, 9'h100, 0);
    chk(w_addr, 32'h0300_0080, "single 4-byte");
    rj(8'h20, 0, 0, 9'h000);
    rj(8'h32, 1, 0, 9'h080);
    rj(8'h32, 1, 0, 9'h100);
    rj(8'h20, 0, 3, 9'h100);
    rj(8'h20, 0, 0, 9'h10B);
    rj(8'h20, 0, 0, 9'h110);
    rj(8'h21, 0, 0, 9'h120);
    stop_test();
  end
endmodule
